// *** flash_tbl_dev.sv ***
// Purpose: table pointer, latch, holding registers, unlock and timed long write
// Assumes: flash array answers a read one cycle after o_mem_rd
// Notes:   all requests are ignored while stall is high
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module flash_tbl_dev #(
   parameter int LONG_CYCLES = flash_tbl_pkg::LONG_CYCLES
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   flash_tbl_if.dev         bus,
   output logic [21:0]      o_mem_addr,
   output logic             o_mem_rd,
   output logic             o_cfg_area,
   input  wire logic [15:0] i_mem_rdata,
   output logic             o_erase_go,
   output logic [15:0]      o_erase_row,
   output logic             o_prog_go,
   output logic [18:0]      o_prog_block,
   output logic [63:0]      o_prog_data,
   output logic             o_long_busy
);
   typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_RD_DATA, ST_LONG} state_t;

   // ==========================================================
   // state
   state_t      state_r,    state_nxt;
   logic [21:0] ptr_r,      ptr_nxt;
   logic [7:0]  latch_r,    latch_nxt;
   logic [7:0]  ctl_r,      ctl_nxt;
   logic [7:0]  hold_r   [flash_tbl_pkg::HOLD_N];
   logic [7:0]  hold_nxt [flash_tbl_pkg::HOLD_N];
   logic        seen55_r,   seen55_nxt;
   logic        armed_r,    armed_nxt;
   logic [15:0] tmr_r,      tmr_nxt;
   logic [21:0] addr_r,     addr_nxt;
   logic        rd_r,       rd_nxt;
   logic        cfg_r,      cfg_nxt;
   logic        ers_r,      ers_nxt;
   logic [15:0] row_r,      row_nxt;
   logic        prg_r,      prg_nxt;
   logic [18:0] blk_r,      blk_nxt;
   logic [63:0] pdata_r,    pdata_nxt;
   logic        stall_r,    stall_nxt;

   logic [21:0] eff;
   logic [7:0]  cw;
   logic        go_ok;

   // ==========================================================
   // next-state logic for the whole sequencer
   always_comb begin
      state_nxt  = state_r;
      ptr_nxt    = ptr_r;
      latch_nxt  = latch_r;
      ctl_nxt    = ctl_r;
      hold_nxt   = hold_r;
      seen55_nxt = seen55_r;
      armed_nxt  = armed_r;
      tmr_nxt    = tmr_r;
      addr_nxt   = addr_r;
      rd_nxt     = 1'b0;
      cfg_nxt    = cfg_r;
      ers_nxt    = 1'b0;
      row_nxt    = row_r;
      prg_nxt    = 1'b0;
      blk_nxt    = blk_r;
      pdata_nxt  = pdata_r;
      cw         = bus.ctl_wdata & flash_tbl_pkg::CTL_MASK;
      go_ok      = 1'b0;
      // pre-increment uses the stepped pointer for this very access
      eff = (bus.tbl_mode == flash_tbl_pkg::MODE_PRE_INC) ?
            flash_tbl_pkg::step_ptr(ptr_r, 1'b0) : ptr_r;
      case (state_r)
         ST_IDLE: begin
            // pointer bytes written directly by the core
            if (bus.ptr_we[0]) begin
               ptr_nxt[7:0] = bus.ptr_wdata;
            end
            if (bus.ptr_we[1]) begin
               ptr_nxt[15:8] = bus.ptr_wdata;
            end
            if (bus.ptr_we[2]) begin
               ptr_nxt[21:16] = bus.ptr_wdata[5:0];
            end
            if (bus.latch_we) begin
               latch_nxt = bus.ptr_we == 3'h0 ? bus.latch_wdata : latch_r;
            end
            // unlock: 55h must be followed directly by AAh on the unlock port
            if (bus.unlock_we) begin
               seen55_nxt = (bus.unlock_wdata == flash_tbl_pkg::UNLOCK_KEY1);
               armed_nxt  = seen55_r && (bus.unlock_wdata == flash_tbl_pkg::UNLOCK_KEY2);
            end
            if (bus.ctl_we) begin
               // the start bit only sticks after a clean unlock with writes enabled
               go_ok = cw[flash_tbl_pkg::CTL_START] && armed_r && cw[flash_tbl_pkg::CTL_NVM_WRITE_ENABLE]
                       && cw[flash_tbl_pkg::CTL_PGM] && !cw[flash_tbl_pkg::CTL_CFG];
               ctl_nxt = cw;
               ctl_nxt[flash_tbl_pkg::CTL_START] = go_ok;
               armed_nxt  = 1'b0;
               seen55_nxt = 1'b0;
               if (go_ok) begin
                  state_nxt = ST_LONG;
                  tmr_nxt   = 16'(LONG_CYCLES);
                  if (cw[flash_tbl_pkg::CTL_ERASE]) begin
                     // always exactly one row, never a larger region
                     ers_nxt = 1'b1;
                     row_nxt = ptr_r[flash_tbl_pkg::PTR_W-1:flash_tbl_pkg::ROW_LSB];
                  end else begin
                     prg_nxt   = 1'b1;
                     blk_nxt   = ptr_r[flash_tbl_pkg::PTR_W-1:flash_tbl_pkg::BLK_LSB];
                     pdata_nxt = {hold_r[7], hold_r[6], hold_r[5], hold_r[4],
                                  hold_r[3], hold_r[2], hold_r[1], hold_r[0]};
                  end
               end
            end else if (bus.table_read_op) begin
               addr_nxt  = eff;
               cfg_nxt   = eff[flash_tbl_pkg::CFG_BIT];
               rd_nxt    = 1'b1;
               state_nxt = ST_RD_WAIT;
            end else if (bus.table_write_op) begin
               hold_nxt[eff[2:0]] = latch_r;
            end
            // post modes step after the access, pre mode keeps the stepped value
            if (!bus.ctl_we && (bus.table_read_op || bus.table_write_op)) begin
               case (bus.tbl_mode)
                  flash_tbl_pkg::MODE_POST_INC: ptr_nxt = flash_tbl_pkg::step_ptr(ptr_r, 1'b0);
                  flash_tbl_pkg::MODE_POST_DEC: ptr_nxt = flash_tbl_pkg::step_ptr(ptr_r, 1'b1);
                  flash_tbl_pkg::MODE_PRE_INC:  ptr_nxt = eff;
                  default:                      ptr_nxt = ptr_r;
               endcase
            end
         end
         // the array word lands on the data bus one cycle after the strobe
         ST_RD_WAIT: state_nxt = ST_RD_DATA;
         ST_RD_DATA: begin
            // bit 0 picks the half of the stored word
            latch_nxt = addr_r[0] ? i_mem_rdata[15:8] : i_mem_rdata[7:0];
            state_nxt = ST_IDLE;
         end
         ST_LONG: begin
            // the programming timer alone ends the stall
            if (tmr_r == 16'h0001) begin
               state_nxt = ST_IDLE;
               ctl_nxt[flash_tbl_pkg::CTL_START] = 1'b0;
            end else begin
               tmr_nxt = tmr_r - 16'h0001;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      stall_nxt = (state_nxt != ST_IDLE);
   end

   // ==========================================================
   // registers
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state_r  <= ST_IDLE;
         ptr_r    <= 22'h000000;
         latch_r  <= 8'h00;
         ctl_r    <= flash_tbl_pkg::CTL_RST;
         for (int i = 0; i < flash_tbl_pkg::HOLD_N; i++) begin
            hold_r[i] <= 8'hFF;
         end
         seen55_r <= 1'b0;
         armed_r  <= 1'b0;
         tmr_r    <= 16'h0000;
         addr_r   <= 22'h000000;
         rd_r     <= 1'b0;
         cfg_r    <= 1'b0;
         ers_r    <= 1'b0;
         row_r    <= 16'h0000;
         prg_r    <= 1'b0;
         blk_r    <= 19'h00000;
         pdata_r  <= 64'h0000000000000000;
         stall_r  <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         ptr_r    <= ptr_nxt;
         latch_r  <= latch_nxt;
         ctl_r    <= ctl_nxt;
         hold_r   <= hold_nxt;
         seen55_r <= seen55_nxt;
         armed_r  <= armed_nxt;
         tmr_r    <= tmr_nxt;
         addr_r   <= addr_nxt;
         rd_r     <= rd_nxt;
         cfg_r    <= cfg_nxt;
         ers_r    <= ers_nxt;
         row_r    <= row_nxt;
         prg_r    <= prg_nxt;
         blk_r    <= blk_nxt;
         pdata_r  <= pdata_nxt;
         stall_r  <= stall_nxt;
      end
   end

   // ==========================================================
   // outputs, all straight from flops
   assign bus.table_pointer   = ptr_r;
   assign bus.table_latch     = latch_r;
   assign bus.nvm_control_reg = ctl_r;
   assign bus.stall           = stall_r;
   assign o_mem_addr   = addr_r;
   assign o_mem_rd     = rd_r;
   assign o_cfg_area   = cfg_r;
   assign o_erase_go   = ers_r;
   assign o_erase_row  = row_r;
   assign o_prog_go    = prg_r;
   assign o_prog_block = blk_r;
   assign o_prog_data  = pdata_r;
   assign o_long_busy  = stall_r;
endmodule // flash_tbl_dev
`default_nettype wire

// *** flash_tbl_pkg.sv ***
// Purpose: shared constants and types for the flash table access and row erase pair
// Assumes: one 20 MHz core clock, synchronous active-low reset
// Notes:   pointer helpers live here; only the table end steps the pointer, the core end never does
//
// Overview of operation
// - table read uses all 22 pointer bits
// - table write: pointer bits 2..0 pick holding register
// - long write: pointer bits 21..3 pick block
// - erase: bits 21..6 pick row, 5..0 ignored
// - four pointer modes: hold, post-inc, post-dec, pre-inc
// - pointer stepping touches only low 21 bits
// - pointer bit 21 selects configuration area
// - table latch is one 8-bit register
// - reads move one byte; address bit 0 picks half
// - erase always clears one 64-byte row
// - no bulk erase from core instructions
// - software sets program, write-enable, erase; clears config
// - unlock 55h then AAh, then write-start
// - load pointer first; disable interrupts before unlock
// - one no-op after write-start, then enable interrupts
// - write-start after unlock erases, stalls about 2 ms
// - programming timer ends long write, then resume
package flash_tbl_pkg;
   // ==========================================================
   // widths
   localparam int PTR_W  = 22;
   localparam int LOW_W  = 21;
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int HOLD_N = 8;
   localparam int ROW_W  = 16;
   localparam int BLK_W  = 19;
   localparam int CFG_BIT = 21;
   localparam int ROW_LSB = 6;
   localparam int BLK_LSB = 3;
   // ==========================================================
   // control register fields and unlock keys
   localparam int CTL_PGM   = 7;
   localparam int CTL_CFG   = 6;
   localparam int CTL_ERASE = 4;
   localparam int CTL_NVM_WRITE_ENABLE  = 2;
   localparam int CTL_START = 1;
   localparam logic [7:0] CTL_RST  = 8'h00;
   localparam logic [7:0] CTL_MASK = 8'hD6;
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   // ==========================================================
   // timing: long write time in microseconds, core clock in MHz
   localparam int LONG_TIME_US = 2000;
   localparam int CLK_MHZ      = 20;
   localparam int LONG_CYCLES  = LONG_TIME_US * CLK_MHZ;
   localparam int TMR_W        = 16;
   // ==========================================================
   // core-side register map (byte offsets on the plain port)
   localparam logic [3:0] REG_PTR_L  = 4'h0;
   localparam logic [3:0] REG_PTR_H  = 4'h1;
   localparam logic [3:0] REG_PTR_U  = 4'h2;
   localparam logic [3:0] REG_LATCH  = 4'h3;
   localparam logic [3:0] REG_CTL    = 4'h4;
   localparam logic [3:0] REG_UNLOCK = 4'h5;
   localparam logic [3:0] REG_TBLOP  = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam int OP_WRITE_BIT = 0;
   localparam int OP_MODE_LSB  = 1;
   // ==========================================================
   typedef enum logic [1:0] {MODE_HOLD, MODE_POST_INC, MODE_POST_DEC, MODE_PRE_INC} tbl_mode_t;

   // step low 21 bits up or down, keep the area select bit
   function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p, input logic dn);
      logic [LOW_W-1:0] low;
      low = dn ? p[LOW_W-1:0] - 21'h000001 : p[LOW_W-1:0] + 21'h000001;
      return {p[CFG_BIT], low};
   endfunction
endpackage

// *** flash_tbl_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// link between the core and the table access logic
interface flash_tbl_if;
   logic        table_read_op;
   logic        table_write_op;
   logic [1:0]  tbl_mode;
   logic [2:0]  ptr_we;
   logic [7:0]  ptr_wdata;
   logic        latch_we;
   logic [7:0]  latch_wdata;
   logic        ctl_we;
   logic [7:0]  ctl_wdata;
   logic        unlock_we;
   logic [7:0]  unlock_wdata;
   logic [21:0] table_pointer;
   logic [7:0]  table_latch;
   logic [7:0]  nvm_control_reg;
   logic        stall;
   modport dev (input  table_read_op, table_write_op, tbl_mode, ptr_we, ptr_wdata,
                       latch_we, latch_wdata, ctl_we, ctl_wdata, unlock_we, unlock_wdata,
                output table_pointer, table_latch, nvm_control_reg, stall);
   modport core (output table_read_op, table_write_op, tbl_mode, ptr_we, ptr_wdata,
                        latch_we, latch_wdata, ctl_we, ctl_wdata, unlock_we, unlock_wdata,
                 input  table_pointer, table_latch, nvm_control_reg, stall);
endinterface // flash_tbl_if
`default_nettype wire

// *** flash_tbl_core.sv ***
// Purpose: core end: turns plain register accesses into table and control requests
// Assumes: software keeps the erase and unlock ordering itself
// Notes:   requests are refused while the device stalls or a table-op or control request is still in flight
`timescale 1ns/1ps
`default_nettype none
module flash_tbl_core (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   flash_tbl_if.core       bus,
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic [7:0]      o_rdata
);
   // ==========================================================
   // request pulses and read data
   logic       rop_r,  rop_nxt;
   logic       wop_r,  wop_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic [2:0] pwe_r,  pwe_nxt;
   logic       lwe_r,  lwe_nxt;
   logic       cwe_r,  cwe_nxt;
   logic       uwe_r,  uwe_nxt;
   logic [7:0] wd_r,   wd_nxt;
   logic [7:0] rd_r,   rd_nxt;
   logic       busy;

   // ==========================================================
   // decode writes into one-cycle requests; a table-op or control pulse in flight counts as busy
   always_comb begin
      busy     = bus.stall | rop_r | wop_r | cwe_r;
      rop_nxt  = 1'b0;
      wop_nxt  = 1'b0;
      mode_nxt = mode_r;
      pwe_nxt  = 3'h0;
      lwe_nxt  = 1'b0;
      cwe_nxt  = 1'b0;
      uwe_nxt  = 1'b0;
      wd_nxt   = wd_r;
      rd_nxt   = rd_r;
      if (i_wr && !busy) begin
         wd_nxt = i_wdata;
         if (i_addr == flash_tbl_pkg::REG_PTR_L) begin
            pwe_nxt = 3'h1;
         end else if (i_addr == flash_tbl_pkg::REG_PTR_H) begin
            pwe_nxt = 3'h2;
         end else if (i_addr == flash_tbl_pkg::REG_PTR_U) begin
            pwe_nxt = 3'h4;
         end else if (i_addr == flash_tbl_pkg::REG_LATCH) begin
            lwe_nxt = 1'b1;
         end else if (i_addr == flash_tbl_pkg::REG_CTL) begin
            cwe_nxt = 1'b1;
         end else if (i_addr == flash_tbl_pkg::REG_UNLOCK) begin
            uwe_nxt = 1'b1;
         end else if (i_addr == flash_tbl_pkg::REG_TBLOP) begin
            wop_nxt  = i_wdata[flash_tbl_pkg::OP_WRITE_BIT];
            rop_nxt  = !i_wdata[flash_tbl_pkg::OP_WRITE_BIT];
            mode_nxt = i_wdata[flash_tbl_pkg::OP_MODE_LSB +: 2];
         end
      end
      // read data stand only in the cycle after the strobe
      if (i_rd) begin
         if (i_addr == flash_tbl_pkg::REG_PTR_L) begin
            rd_nxt = bus.table_pointer[7:0];
         end else if (i_addr == flash_tbl_pkg::REG_PTR_H) begin
            rd_nxt = bus.table_pointer[15:8];
         end else if (i_addr == flash_tbl_pkg::REG_PTR_U) begin
            rd_nxt = {2'h0, bus.table_pointer[21:16]};
         end else if (i_addr == flash_tbl_pkg::REG_LATCH) begin
            rd_nxt = bus.table_latch;
         end else if (i_addr == flash_tbl_pkg::REG_CTL) begin
            rd_nxt = bus.nvm_control_reg;
         end else if (i_addr == flash_tbl_pkg::REG_STATUS) begin
            rd_nxt = {7'h00, busy};
         end else begin
            rd_nxt = 8'h00;
         end
      end else begin
         rd_nxt = 8'h00;
      end
   end

   // ==========================================================
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         rop_r  <= 1'b0;
         wop_r  <= 1'b0;
         mode_r <= 2'h0;
         pwe_r  <= 3'h0;
         lwe_r  <= 1'b0;
         cwe_r  <= 1'b0;
         uwe_r  <= 1'b0;
         wd_r   <= 8'h00;
         rd_r   <= 8'h00;
      end else begin
         rop_r  <= rop_nxt;
         wop_r  <= wop_nxt;
         mode_r <= mode_nxt;
         pwe_r  <= pwe_nxt;
         lwe_r  <= lwe_nxt;
         cwe_r  <= cwe_nxt;
         uwe_r  <= uwe_nxt;
         wd_r   <= wd_nxt;
         rd_r   <= rd_nxt;
      end
   end

   // ==========================================================
   // one shared data byte feeds every write port of the link
   assign bus.table_read_op  = rop_r;
   assign bus.table_write_op = wop_r;
   assign bus.tbl_mode       = mode_r;
   assign bus.ptr_we         = pwe_r;
   assign bus.ptr_wdata      = wd_r;
   assign bus.latch_we       = lwe_r;
   assign bus.latch_wdata    = wd_r;
   assign bus.ctl_we         = cwe_r;
   assign bus.ctl_wdata      = wd_r;
   assign bus.unlock_we      = uwe_r;
   assign bus.unlock_wdata   = wd_r;
   assign o_rdata            = rd_r;
endmodule // flash_tbl_core
`default_nettype wire

// *** flash_tbl_props.sv ***
// Purpose: checks on the link between the core end and the flash table end
// Assumes: one core clock, synchronous active-low reset
// Notes:   unlock state is rebuilt here from the link writes
`timescale 1ns/1ps
`default_nettype none
module flash_tbl_props #(
   parameter int LONG_CYCLES = 20
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        table_read_op,
   input  wire logic        table_write_op,
   input  wire logic [1:0]  tbl_mode,
   input  wire logic        ctl_we,
   input  wire logic [7:0]  ctl_wdata,
   input  wire logic        unlock_we,
   input  wire logic [7:0]  unlock_wdata,
   input  wire logic [21:0] table_pointer,
   input  wire logic [7:0]  nvm_control_reg,
   input  wire logic        stall
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // ==========================================================
   // helper state
   logic key_r, key_nxt, arm_r, arm_nxt, op, good;
   int   cnt_r, cnt_nxt;
   // stalled link pulses are ignored, so they must not move the unlock state
   always_comb begin
      op = (table_read_op | table_write_op) & ~stall & ~ctl_we;
      good = ctl_wdata[7] & ~ctl_wdata[6] & ctl_wdata[2] & ctl_wdata[1];
      key_nxt = key_r;
      arm_nxt = arm_r;
      if (!stall && ctl_we) begin
         key_nxt = 1'b0;
         arm_nxt = 1'b0;
      end else if (!stall && unlock_we) begin
         key_nxt = (unlock_wdata == 8'h55);
         arm_nxt = key_r & (unlock_wdata == 8'hAA);
      end
      cnt_nxt = stall ? cnt_r + 1 : 0;
   end
   // register the helper state
   always_ff @(posedge i_mclk) begin
      key_r <= i_rst_n ? key_nxt : 1'b0;
      arm_r <= i_rst_n ? arm_nxt : 1'b0;
      cnt_r <= i_rst_n ? cnt_nxt : 0;
   end
   // ==========================================================
   // properties
   sequence s_rd_busy;
      stall ##1 stall ##1 !stall;
   endsequence
   sequence s_long_on;
      stall && nvm_control_reg[1];
   endsequence
   property p_rd;
      table_read_op && !stall && !ctl_we |=> s_rd_busy;
   endproperty
   property p_hold;
      op && tbl_mode == 2'h0 |=> table_pointer == $past(table_pointer);
   endproperty
   property p_inc;
      op && tbl_mode[0] |=> table_pointer[20:0] == $past(table_pointer[20:0]) + 21'h000001;
   endproperty
   property p_dec;
      op && tbl_mode == 2'h2 |=> table_pointer[20:0] == $past(table_pointer[20:0]) - 21'h000001;
   endproperty
   property p_top;
      op |=> table_pointer[21] == $past(table_pointer[21]);
   endproperty
   property p_wr;
      table_write_op && !stall && !ctl_we |=> !stall;
   endproperty
   property p_go;
      ctl_we && !stall && arm_r && good |=> s_long_on;
   endproperty
   property p_refuse;
      ctl_we && !stall && !(arm_r && good) |=> !stall && !nvm_control_reg[1];
   endproperty
   property p_len;
      $fell(stall) && $past(nvm_control_reg[1]) |-> cnt_r == LONG_CYCLES;
   endproperty
   property p_cap;
      stall |-> cnt_r < LONG_CYCLES;
   endproperty
   property p_bit;
      nvm_control_reg[1] |-> stall;
   endproperty
   a_rd: assert property (p_rd) else $error("table read stall shape wrong");
   a_hold: assert property (p_hold) else $error("pointer moved in hold mode");
   a_inc: assert property (p_inc) else $error("pointer increment wrong");
   a_dec: assert property (p_dec) else $error("pointer decrement wrong");
   a_top: assert property (p_top) else $error("pointer top bit changed");
   a_wr: assert property (p_wr) else $error("table write stalled");
   a_go: assert property (p_go) else $error("armed start did not begin");
   a_refuse: assert property (p_refuse) else $error("start taken unarmed");
   a_len: assert property (p_len) else $error("long write length wrong");
   a_cap: assert property (p_cap) else $error("long write overran");
   a_bit: assert property (p_bit) else $error("start bit outlived stall");
endmodule // flash_tbl_props
`default_nettype wire

// *** test_program_flash_table_access_erase.sv ***
// Purpose: drives the core register port and plays the flash array
// Assumes: array word depends on all word address bits
// Notes:   long write shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module test_program_flash_table_access_erase;
   localparam int LONG = 20;
   localparam logic [7:0] UK [4][3] = '{'{8'h55, 8'h12, 8'hAA}, '{8'h12, 8'h55, 8'hAA},
                                        '{8'h12, 8'h55, 8'hAA}, '{8'h55, 8'hAA, 8'h55}};
   localparam logic [7:0] GO [4] = '{8'h96, 8'hF6, 8'h92, 8'h96};
   logic        i_mclk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic [21:0] mem_addr;
   logic        mem_rd, cfg_area, erase_go, prog_go, long_busy;
   logic [15:0] mem_rdata = 16'h0000;
   logic [15:0] erase_row;
   logic [18:0] prog_block;
   logic [63:0] prog_data;
   int failures = 0;
   int cmp_count = 0;
   int n_erase = 0;
   int n_prog = 0;
   int n_stall = 0;
   // ==========================================================
   // design, link and checker
   flash_tbl_if link ();
   flash_tbl_core flash_tbl_core_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(link),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
   flash_tbl_dev #(.LONG_CYCLES(LONG)) flash_tbl_dev_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .bus(link), .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .o_cfg_area(cfg_area),
      .i_mem_rdata(mem_rdata), .o_erase_go(erase_go), .o_erase_row(erase_row),
      .o_prog_go(prog_go), .o_prog_block(prog_block), .o_prog_data(prog_data),
      .o_long_busy(long_busy));
   flash_tbl_props #(.LONG_CYCLES(LONG)) flash_tbl_props_inst (.i_mclk(i_mclk),
      .i_rst_n(i_rst_n), .table_read_op(link.table_read_op),
      .table_write_op(link.table_write_op), .tbl_mode(link.tbl_mode), .ctl_we(link.ctl_we),
      .ctl_wdata(link.ctl_wdata), .unlock_we(link.unlock_we),
      .unlock_wdata(link.unlock_wdata), .table_pointer(link.table_pointer),
      .nvm_control_reg(link.nvm_control_reg), .stall(link.stall));
   always #25 i_mclk = ~i_mclk;
   // array answers one cycle late; between answers the bus shows junk
   always @(posedge i_mclk) begin
      mem_rdata <= (mem_rd === 1'b1) ? fw(mem_addr) : ~mem_rdata;
      n_erase <= n_erase + ((erase_go === 1'b1) ? 1 : 0);
      n_prog <= n_prog + ((prog_go === 1'b1) ? 1 : 0);
      n_stall <= n_stall + ((long_busy === 1'b1) ? 1 : 0);
   end
   // ==========================================================
   // helpers
   function automatic logic [15:0] fw(input logic [21:0] a);
      return {a[16:9] ^ 8'hA5, a[8:1] ^ {2'h0, a[21:16]}};
   endfunction
   function automatic logic [21:0] nxt(input logic [21:0] p, input logic dn);
      return {p[21], dn ? p[20:0] - 21'h000001 : p[20:0] + 21'h000001};
   endfunction
   task automatic end_of_test;
      if (failures == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_idle;
      logic [7:0] s;
      for (int i = 0; i < 100; i++) begin
         rd_reg(flash_tbl_pkg::REG_STATUS, s);
         if (s[0] === 1'b0) return;
      end
      failures++;
      $display("[ERR] %0t busy never cleared", $time);
      end_of_test();
   endtask
   task automatic set_ptr(input logic [21:0] p);
      wr_reg(4'h0, p[7:0]);
      wr_reg(4'h1, p[15:8]);
      wr_reg(4'h2, {2'h0, p[21:16]});
   endtask
   task automatic rd_ptr(output logic [21:0] p);
      logic [7:0] l, h, u;
      rd_reg(4'h0, l);
      rd_reg(4'h1, h);
      rd_reg(4'h2, u);
      p = {u[5:0], h, l};
   endtask
   task automatic arm_start(input logic [7:0] u0, u1, u2, go);
      wr_reg(flash_tbl_pkg::REG_UNLOCK, u0);
      wr_reg(flash_tbl_pkg::REG_UNLOCK, u1);
      wr_reg(flash_tbl_pkg::REG_UNLOCK, u2);
      wr_reg(flash_tbl_pkg::REG_CTL, go);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      logic [7:0] d;
      wr_reg(4'hC, 8'h5A);
      for (int a = 0; a < 16; a++) begin
         rd_reg(4'(a), d);
         chk(d, 8'h00);
      end
   endtask
   task automatic t_read;
      logic [21:0] p, e, q;
      logic [15:0] w;
      logic [7:0]  d;
      for (int i = 0; i < 8; i++) begin
         p = (i < 4) ? 22'h3F_FFFF : 22'h0A_5C3E;
         set_ptr(p);
         wr_reg(flash_tbl_pkg::REG_TBLOP, {5'h00, 2'(i % 4), 1'b0});
         wait_idle();
         e = (i % 4 == 3) ? nxt(p, 1'b0) : p;
         w = fw(e);
         rd_reg(flash_tbl_pkg::REG_LATCH, d);
         chk(d, e[0] ? w[15:8] : w[7:0]);
         chk(cfg_area, e[21]);
         rd_ptr(q);
         chk(q, (i % 4 == 0) ? p : nxt(p, i % 4 == 2));
      end
   endtask
   task automatic t_prog;
      logic [63:0] exp;
      logic [21:0] e;
      int np;
      e = 22'h01_234D;
      set_ptr(22'h01_2345);
      for (int k = 0; k < 8; k++) begin
         wr_reg(flash_tbl_pkg::REG_LATCH, 8'(16 + k));
         wr_reg(flash_tbl_pkg::REG_TBLOP, 8'h03);
         wait_idle();
         exp[8 * ((5 + k) % 8) +: 8] = 8'(16 + k);
      end
      np = n_prog;
      wr_reg(flash_tbl_pkg::REG_CTL, 8'h84);
      arm_start(8'h55, 8'h55, 8'hAA, 8'h86);
      wait_idle();
      chk(n_prog - np, 1);
      chk(prog_block, e[21:3]);
      chk(prog_data, exp);
   endtask
   task automatic t_erase;
      logic [21:0] q;
      logic [7:0]  d;
      int ne, ns;
      ne = n_erase;
      ns = n_stall;
      set_ptr(22'h0A_BCFF);
      wr_reg(flash_tbl_pkg::REG_CTL, 8'h94);
      arm_start(8'h12, 8'h55, 8'hAA, 8'h96);
      wr_reg(4'h0, 8'h00);
      rd_reg(flash_tbl_pkg::REG_STATUS, d);
      chk(d[0], 1'b1);
      wait_idle();
      chk(n_erase - ne, 1);
      chk(erase_row, 16'h2AF3);
      chk(n_stall - ns, LONG);
      rd_ptr(q);
      chk(q, 22'h0A_BCFF);
      rd_reg(flash_tbl_pkg::REG_CTL, d);
      chk(d, 8'h94);
   endtask
   task automatic t_locked;
      logic [7:0] d;
      int n;
      for (int c = 0; c < 4; c++) begin
         n = n_erase + n_prog;
         wr_reg(flash_tbl_pkg::REG_CTL, 8'h94);
         arm_start(UK[c][0], UK[c][1], UK[c][2], GO[c]);
         wait_idle();
         rd_reg(flash_tbl_pkg::REG_CTL, d);
         chk(d, GO[c] & 8'hD4);
         chk(n_erase + n_prog - n, 0);
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      t_reset();
      t_read();
      t_prog();
      t_erase();
      t_locked();
      end_of_test();
   end
endmodule // test_program_flash_table_access_erase
`default_nettype wire
